// File: hdl/serial_rtc_calendar_core.sv
/*
  Serial clock/calendar core: BCD time and date counters, 56-byte store,
  square-wave output, supply-fail lockout, two-wire target port and an
  AHB-Lite window onto the same 64 registers.
  Assumes a 250 MHz clk, pin levels from outside this clock domain, and a
  supply comparator that raises powerFailIn when the main supply is low.
*/
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
// Contract
// [R1] Host opens with start, target ID, register address; target only.
// [R2] Following bytes read or written at consecutive locations until stop.
// [R3] Supply fail aborts any transfer and clears the register pointer.
// [R4] During supply fail all bus inputs are ignored.
// [R5] Bus inputs are accepted again once supply fail releases.
// [R6] Time keeps counting while supply fail blocks access.
// [R7] Separate readable seconds to year counters.
// [R8] Date rolls over at true month end, February leap-corrected.
// [R9] Square-wave enable selects one of four clock-derived rates.
// [R10] External 32.768 kHz clock on crystal input; crystal output floats.
// [R11] 56 bytes of retained general-purpose storage.
// [R12] Clock at 00h-07h, RAM 08h-3Fh, pointer wraps 3Fh to 00h.
// [R13] Rate codes 1 Hz/4.096/8.192/32.768 kHz; disabled pin follows level.
// [R14] Reads use shadows copied at start; seconds write resets divider.
// [R15] Seconds bit 7 halts oscillator and counting.
// [R16] Each received byte acknowledged; pointer increments after each byte.
`timescale 1ns/1ns
`include "rtc_regs.svh"
module serial_rtc_calendar_core #(
  parameter logic [6:0] TARGET_ADDR = `RTC_TARGET_ADDR
) (
  input  wire logic        clk,           // System clock.
  input  wire logic        rst,           // Synchronous reset.
  input  wire logic        sclPin,        // Bus clock pin.
  input  wire logic        sdaIn,         // Bus data pin level.
  output logic             sdaOut,        // Bus data drive value.
  output logic             sdaOe,         // Bus data pull-down enable.
  input  wire logic        crystalInPin,  // 32.768 kHz clock input.
  output logic             crystalOutPin, // Oscillator output value.
  output logic             crystalOutOe,  // Oscillator output enable.
  input  wire logic        powerFailIn,   // Supply comparator trip.
  output logic             squareWavePin, // Square-wave drive value.
  output logic             squareWaveOe,  // Square-wave pull-down.
  input  wire logic        hsel,          // AHB select.
  input  wire logic [31:0] haddr,         // AHB address.
  input  wire logic [1:0]  htrans,        // AHB transfer type.
  input  wire logic        hwrite,        // AHB write.
  input  wire logic [2:0]  hsize,         // AHB size.
  input  wire logic [31:0] hwdata,        // AHB write data.
  input  wire logic        hready,        // AHB bus ready.
  output logic             hreadyout,     // AHB slave ready.
  output logic             hresp,         // AHB response.
  output logic [31:0]      hrdata         // AHB read data.
);
  import rtc_pkg::*;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [63:0] WMASK = `RTC_WMASK;

  core_t      q;
  core_t      d;
  rtc_reg_if  regIf ();
  logic       xtalTick;
  logic       halted;
  logic       secTick;
  logic       powerFail;
  logic       tap;
  logic       ahbReq;
  logic [5:0] reqIdx;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Next BCD value; callers handle their own upper limits.
  function automatic byte_t bcdInc(input byte_t v);
    if (v[3:0] == 4'h9) begin
      bcdInc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcdInc = v + 8'h01;
    end
  endfunction : bcdInc

  // Last date of a month, in BCD, with the leap rule for two-digit years.
  function automatic byte_t lastDate(input byte_t mon, input byte_t yr);
    logic leap;
    leap = (~yr[4] & (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8)) |
           (yr[4] & (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
    case (mon[4:0])
      5'h02:   lastDate = leap ? 8'h29 : 8'h28; // [R8]
      5'h04, 5'h06, 5'h09, 5'h11:
               lastDate = 8'h30; // [R8]
      default: lastDate = 8'h31;
    endcase
  endfunction : lastDate

  // Byte seen at an index; shadows serve the time registers to the port.
  function automatic byte_t getByte(input core_t s, input logic [5:0] i,
                                    input logic sh);
    if (i < `RTC_IDX_CTRL && sh) begin
      getByte = s.shadow[i[2:0]]; // [R14]
    end else if (i < `RTC_IDX_RAM) begin
      getByte = s.live[i[2:0]]; // [R7]
    end else begin
      getByte = s.ram[6'(i - `RTC_IDX_RAM)]; // [R11]
    end
  endfunction : getByte

  // Store a byte; unused bits stay zero, a seconds write restarts the
  // divider so the next second is a full one.
  function automatic core_t putByte(input core_t s, input logic [5:0] i,
                                    input byte_t v);
    core_t r;
    r = s;
    if (i < `RTC_IDX_RAM) begin
      r.live[i[2:0]] = v & WMASK[{i[2:0], 3'b000} +: 8];
      if (i == `RTC_IDX_SEC) begin
        r.div = 15'h0000; // [R14]
      end
    end else begin
      r.ram[6'(i - `RTC_IDX_RAM)] = v; // [R11]
    end
    putByte = r;
  endfunction : putByte

  // ----------------------------------------------------------------
  // Serial target port
  // ----------------------------------------------------------------
  i2c_target_engine #(
    .TARGET_ADDR (TARGET_ADDR)
  ) u_engine (
    .clk       (clk),
    .rst       (rst),
    .sclPin    (sclPin),
    .sdaIn     (sdaIn),
    .sdaOe     (sdaOe),
    .powerFail (powerFail),
    .regs      (regIf.engine)
  );

  // Reads through the port see shadows for time, live control and RAM.
  assign regIf.rdata = getByte(q, regIf.addr, 1'b1); // [R2]

  // ----------------------------------------------------------------
  // Pins and bus answers
  // ----------------------------------------------------------------
  assign powerFail     = q.pfS[1]; // [R5]
  assign xtalTick      = q.xS[1] & ~q.xP;
  assign halted        = q.live[0][`RTC_BIT_HALT];
  assign secTick       = xtalTick & ~halted & (q.div == `RTC_DIV_TOP);
  assign sdaOut        = 1'b0;
  assign crystalOutPin = 1'b0;
  assign crystalOutOe  = 1'b0; // [R10]
  assign squareWavePin = 1'b0;
  assign squareWaveOe  = ~q.sqw; // [R13]
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = q.hrdata;
  assign ahbReq        = hsel & htrans[1] & hready;
  assign reqIdx        = haddr[7:2];

  // Rate taps: the 1 Hz tap falls exactly when the seconds advance.
  always_comb begin
    case (q.live[7][1:0])
      2'b00:   tap = q.div[14]; // [R13]
      2'b01:   tap = q.div[2]; // [R13]
      2'b10:   tap = q.div[1]; // [R13]
      default: tap = q.xS[1] & ~halted; // [R13]
    endcase
  end

  // ----------------------------------------------------------------
  // Timekeeping, register writes and bus slave
  // ----------------------------------------------------------------

  // Counting never looks at powerFail, so time runs through lockout.
  always_comb begin
    d = q;
    d.xS  = {q.xS[0], crystalInPin}; // [R10]
    d.xP  = q.xS[1];
    d.pfS = {q.pfS[0], powerFailIn}; // [R3]
    if (xtalTick && !halted) begin
      d.div = q.div + 15'h0001; // [R15]
    end
    if (secTick) begin // [R6]
      d.live[0] = bcdInc(q.live[0]); // [R7]
      if (q.live[0][6:0] == 7'h59) begin
        d.live[0] = 8'h00;
        d.live[1] = bcdInc(q.live[1]);
        if (q.live[1] == 8'h59) begin
          d.live[1] = 8'h00;
          d.live[2] = bcdInc(q.live[2]);
          if (q.live[2][`RTC_BIT_MODE12]) begin
            if (q.live[2][4:0] == 5'h11) begin
              d.live[2] = q.live[2] ^ 8'h23; // To 12, flip AM/PM.
            end else if (q.live[2][4:0] == 5'h12) begin
              d.live[2] = {q.live[2][7:5], 5'h01};
            end
          end else if (q.live[2][5:0] == 6'h23) begin
            d.live[2] = 8'h00;
          end
          if ((q.live[2][6] && q.live[2][5] &&
               q.live[2][4:0] == 5'h11) ||
              (!q.live[2][6] && q.live[2][5:0] == 6'h23)) begin
            d.live[3] = (q.live[3] == 8'h07) ? 8'h01 : bcdInc(q.live[3]);
            d.live[4] = bcdInc(q.live[4]);
            if (q.live[4] == lastDate(q.live[5], q.live[6])) begin
              d.live[4] = 8'h01; // [R8]
              d.live[5] = bcdInc(q.live[5]);
              if (q.live[5] == 8'h12) begin
                d.live[5] = 8'h01;
                d.live[6] = (q.live[6] == 8'h99) ? 8'h00 :
                            bcdInc(q.live[6]);
              end
            end
          end
        end
      end
    end
    if (q.live[7][`RTC_BIT_SQUARE_WAVE_ENABLE]) begin
      d.sqw = tap; // [R9]
    end else begin
      d.sqw = q.live[7][`RTC_BIT_OUTLVL]; // [R13]
    end
    // A start freezes a copy of the time for the coming reads.
    if (regIf.startSeen) begin
      d.shadow = q.live[6:0]; // [R14]
    end
    // Port writes land on the acknowledge, after counting.
    if (regIf.wrEn) begin
      d = putByte(d, regIf.addr, regIf.wdata); // [R2]
    end
    // AHB data phase write; the bus has the last word this cycle.
    if (q.ahbWr) begin
      d = putByte(d, q.ahbIdx, hwdata[7:0]);
    end
    // AHB address phase; reads return live values, with a bypass so a
    // read right after a write to the same index sees the new byte.
    d.ahbWr  = 1'b0;
    d.hrdata = 32'h0000_0000;
    if (ahbReq && haddr[31:8] == 24'h00_0000) begin
      d.ahbWr  = hwrite;
      d.ahbIdx = reqIdx;
      if (!hwrite) begin
        d.hrdata = {24'h00_0000, getByte(d, reqIdx, 1'b0)};
      end
    end
    if (rst) begin
      d         = '0;
      d.live[0] = `RTC_RST_SEC; // [R15]
      d.live[3] = `RTC_RST_ONE;
      d.live[4] = `RTC_RST_ONE;
      d.live[5] = `RTC_RST_ONE;
      d.live[7] = `RTC_RST_CTRL;
    end
  end

  // Whole-state register.
  always_ff @(posedge clk) begin
    q <= d;
  end

endmodule : serial_rtc_calendar_core

// File: hdl/rtc_regs.svh
/*
  Register indices, field positions, reset values and timing constants of
  the serial clock/calendar core. Included by bare name; definitions only.
*/
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Register indices; the bus byte address is four times the index.
`define RTC_IDX_SEC      6'h00
`define RTC_IDX_MIN      6'h01
`define RTC_IDX_HOUR     6'h02
`define RTC_IDX_DOW      6'h03
`define RTC_IDX_DATE     6'h04
`define RTC_IDX_MONTH    6'h05
`define RTC_IDX_YEAR     6'h06
`define RTC_IDX_CTRL     6'h07
`define RTC_IDX_RAM      6'h08
`define RTC_IDX_LAST     6'h3F

// Field positions.
`define RTC_BIT_HALT     7
`define RTC_BIT_MODE12   6
`define RTC_BIT_PM       5
`define RTC_BIT_OUTLVL   7
`define RTC_BIT_SQUARE_WAVE_ENABLE     4

// Writable bits of registers 0 to 7, byte i at bits 8*i+7:8*i.
`define RTC_WMASK        64'h93FF_1F3F_077F_7FFF

// First power-up contents: halted, 01/01/00, day 1, 00:00:00.
`define RTC_RST_SEC      8'h80
`define RTC_RST_ONE      8'h01
`define RTC_RST_CTRL     8'h03

// Timekeeping clock and target identification (value is arbitrary).
`define RTC_XTAL_HZ      32768
`define RTC_DIV_TOP      15'h7FFF
`define RTC_TARGET_ADDR  7'h2A

`endif

// File: hdl/rtc_pkg.sv
/*
  Types of the clock/calendar core: state encodings and the packed state
  records of the serial engine and of the register store.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rtc_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    XF_IDLE, XF_RX, XF_RXACK, XF_TX, XF_TXACK
  } xfer_state_t;

  typedef enum logic [1:0] {PH_DEV, PH_REG, PH_DATA} byte_phase_t;

  typedef struct packed {
    xfer_state_t st;
    byte_phase_t ph;
    byte_t       shift;
    logic [3:0]  cnt;
    logic        rw;
    logic        nack;
    logic        drive;
    logic [5:0]  ptr;
    logic [1:0]  sclS;
    logic [1:0]  sdaS;
    logic        sclP;
    logic        sdaP;
  } xfer_t;

  typedef struct packed {
    logic [1:0]    xS;
    logic          xP;
    logic [1:0]    pfS;
    logic [14:0]   div;
    byte_t [7:0]   live;
    byte_t [6:0]   shadow;
    byte_t [55:0]  ram;
    logic          sqw;
    logic          ahbWr;
    logic [5:0]    ahbIdx;
    logic [31:0]   hrdata;
  } core_t;

endpackage : rtc_pkg

// File: hdl/rtc_reg_if.sv
/*
  Carrier between the serial engine and the register store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface rtc_reg_if;
  logic       startSeen;  // One-cycle pulse on each start condition outside supply fail.
  logic       wrEn;       // One-cycle write strobe.
  logic [5:0] addr;       // Register pointer.
  logic [7:0] wdata;      // Byte to store.
  logic [7:0] rdata;      // Byte at addr, combinational.

  modport engine (output startSeen, wrEn, addr, wdata, input rdata);
  modport store  (input startSeen, wrEn, addr, wdata, output rdata);
endinterface : rtc_reg_if

// File: hdl/i2c_target_engine.sv
/*
  Two-wire bus target engine: start/stop detection, address match,
  byte shifting, acknowledge and the auto-incrementing register pointer.
  Assumes raw pin levels on sclPin/sdaIn and a synchronised powerFail.
*/
`timescale 1ns/1ns
`include "rtc_regs.svh"
module i2c_target_engine #(
  parameter logic [6:0] TARGET_ADDR = `RTC_TARGET_ADDR
) (
  input  wire logic  clk,        // System clock.
  input  wire logic  rst,        // Synchronous reset.
  input  wire logic  sclPin,     // Bus clock pin level.
  input  wire logic  sdaIn,      // Bus data pin level.
  output logic       sdaOe,      // High pulls data low.
  input  wire logic  powerFail,  // Synchronised supply-fail level.
  rtc_reg_if.engine  regs        // Register access.
);
  import rtc_pkg::*;

  xfer_t q;
  xfer_t d;
  logic  scl, sda, sclRise, sclFall, start, stop;

  // --------------------------------------------------------------
  // Edge detection on the second synchroniser stage only.
  // --------------------------------------------------------------
  assign scl     = q.sclS[1];
  assign sda     = q.sdaS[1];
  assign sclRise = scl & ~q.sclP;
  assign sclFall = ~scl & q.sclP;
  assign start   = scl & q.sclP & ~sda & q.sdaP;
  assign stop    = scl & q.sclP & sda & ~q.sdaP;
  assign sdaOe   = q.drive;

  // Next-state logic; the bus clock is only ever read, never driven.
  always_comb begin
    d = q;
    regs.startSeen = 1'b0;
    regs.wrEn      = 1'b0;
    regs.addr      = q.ptr;
    regs.wdata     = q.shift;
    d.sclS = {q.sclS[0], sclPin};
    d.sdaS = {q.sdaS[0], sdaIn};
    d.sclP = q.sclS[1];
    d.sdaP = q.sdaS[1];
    if (powerFail) begin
      d.st    = XF_IDLE; // [R3]
      d.ptr   = 6'h00; // [R3]
      d.drive = 1'b0; // [R4]
    end else if (start) begin
      d.st    = XF_RX; // [R1]
      d.ph    = PH_DEV;
      d.cnt   = 4'h0;
      d.drive = 1'b0;
      regs.startSeen = 1'b1;
    end else if (stop) begin
      d.st    = XF_IDLE; // [R2]
      d.drive = 1'b0;
    end else begin
      case (q.st)
        XF_RX: begin
          if (sclRise) begin
            d.shift = {q.shift[6:0], sda};
            d.cnt   = q.cnt + 4'h1;
          end else if (sclFall && q.cnt == 4'h8) begin
            d.cnt   = 4'h0;
            d.drive = 1'b1; // [R16]
            d.st    = XF_RXACK;
            case (q.ph)
              PH_DEV: begin
                d.rw = q.shift[0];
                if (q.shift[7:1] != TARGET_ADDR) begin
                  d.drive = 1'b0; // [R1]
                  d.st    = XF_IDLE;
                end
              end
              PH_REG:  d.ptr = q.shift[5:0]; // [R1]
              default: regs.wrEn = 1'b1; // [R2]
            endcase
          end
        end
        XF_RXACK: begin
          if (sclFall) begin
            d.drive = 1'b0;
            d.st    = XF_RX;
            if (q.ph == PH_DEV && q.rw) begin
              d.shift = regs.rdata; // [R2]
              d.drive = ~regs.rdata[7];
              d.ptr   = q.ptr + 6'h01; // [R16]
              d.cnt   = 4'h1;
              d.st    = XF_TX;
            end else if (q.ph == PH_DEV) begin
              d.ph = PH_REG;
            end else if (q.ph == PH_REG) begin
              d.ph = PH_DATA;
            end else begin
              d.ptr = q.ptr + 6'h01; // [R12]
            end
          end
        end
        XF_TX: begin
          if (sclFall && q.cnt == 4'h8) begin
            d.drive = 1'b0;
            d.st    = XF_TXACK;
          end else if (sclFall) begin
            d.shift = {q.shift[6:0], 1'b0};
            d.drive = ~q.shift[6];
            d.cnt   = q.cnt + 4'h1;
          end
        end
        XF_TXACK: begin
          if (sclRise) begin
            d.nack = sda;
          end else if (sclFall && q.nack) begin
            d.st = XF_IDLE;
          end else if (sclFall) begin
            d.shift = regs.rdata; // [R2]
            d.drive = ~regs.rdata[7];
            d.ptr   = q.ptr + 6'h01; // [R16]
            d.cnt   = 4'h1;
            d.st    = XF_TX;
          end
        end
        default: d.st = XF_IDLE;
      endcase
    end
    if (rst) begin
      d = '0;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    q <= d;
  end

endmodule : i2c_target_engine

// File: bench/rtc_monitor.sv
/*
  Checker for the clock/calendar core, bound to its top module.
  Assumes single-word AHB-Lite transfers and an open-drain data line.
*/
`timescale 1ns/1ns
module rtc_monitor (
  input wire logic        clk,          // System clock.
  input wire logic        rst,          // Synchronous reset.
  input wire logic        sdaOut,       // Data drive value.
  input wire logic        sdaOe,        // Data pull-down enable.
  input wire logic        crystalOutOe, // Oscillator output enable.
  input wire logic        powerFailIn,  // Supply comparator trip.
  input wire logic        hsel,         // AHB select.
  input wire logic [31:0] haddr,        // AHB address.
  input wire logic [1:0]  htrans,       // AHB transfer type.
  input wire logic        hwrite,       // AHB write.
  input wire logic        hready,       // AHB bus ready.
  input wire logic        hreadyout,    // AHB slave ready.
  input wire logic        hresp,        // AHB response.
  input wire logic [31:0] hrdata        // AHB read data.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A read address phase is accepted at this edge.
  logic rdAcc;
  assign rdAcc = hsel && htrans[1] && hready && !hwrite;

  property p_open_drain;
    sdaOut == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin drives high");
  property p_xtal_float;
    crystalOutOe == 1'b0;
  endproperty
  a_xtal_float: assert property (p_xtal_float)
    else $error("crystal output driven");
  // Synchronisers and the engine register need a few cycles to see it.
  property p_pf_quiet;
    powerFailIn [*6] |-> !sdaOe;
  endproperty
  a_pf_quiet: assert property (p_pf_quiet)
    else $error("data pulled during supply fail");
  property p_pf_abort;
    $rose(powerFailIn) |-> ##[1:8] !sdaOe;
  endproperty
  a_pf_abort: assert property (p_pf_abort)
    else $error("transfer not aborted on supply fail");
  property p_reset;
    disable iff (1'b0) rst |=> (!sdaOe && hrdata == 32'h0);
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not idle after reset");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("slave not ready or not okay");
  property p_rd_idle;
    !$past(rdAcc) |-> hrdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside data phase");
  property p_byte_wide;
    hrdata[31:8] == 24'h0;
  endproperty
  a_byte_wide: assert property (p_byte_wide)
    else $error("upper read data bits set");
  property p_unmapped;
    rdAcc && haddr[31:8] != 24'h0 |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
  property p_ctrl_zero;
    rdAcc && haddr == 32'h1C |=> (hrdata & 32'h6C) == 32'h0;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("control reserved bits set");
endmodule : rtc_monitor

bind serial_rtc_calendar_core rtc_monitor mon (
  .clk, .rst, .sdaOut, .sdaOe, .crystalOutOe, .powerFailIn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata);

// File: bench/i2c_host_model.sv
/*
  Behavioural two-wire bus controller standing for the host.
  Assumes a pull-up on the data line, resolved by the bench.
*/
`timescale 1ns/1ns
module i2c_host_model #(
  parameter int Q = 8
) (
  input  wire logic clk,   // Bench clock.
  input  wire logic sda,   // Resolved data line.
  output logic      scl,   // Bus clock, idles high between frames.
  output logic      sdaOe  // High pulls data low.
);
  initial begin
    scl = 1'b1;
    sdaOe = 1'b0;
  end
  task automatic w;
    repeat (Q) @(posedge clk);
  endtask : w
  // Data changes only while the clock is low, so no false start or stop.
  task automatic bitx(input logic b, output logic r);
    sdaOe <= !b;
    w();
    scl <= 1'b1;
    w();
    r = sda;
    w();
    scl <= 1'b0;
    w();
  endtask : bitx
  // Also serves as repeated start from the clock-low state.
  task automatic start;
    sdaOe <= 1'b0;
    w();
    scl <= 1'b1;
    w();
    sdaOe <= 1'b1;
    w();
    scl <= 1'b0;
    w();
  endtask : start
  task automatic stop;
    sdaOe <= 1'b1;
    w();
    scl <= 1'b1;
    w();
    sdaOe <= 1'b0;
    w();
  endtask : stop
  task automatic tx(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : tx
  task automatic rx(input logic ackIt, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      v[i] = r;
    end
    bitx(!ackIt, r);
  endtask : rx
endmodule : i2c_host_model

// File: bench/testbench.sv
/*
  Self-checking bench: AHB-Lite register access, two-wire host traffic,
  square-wave rates and supply-fail lockout.
  Assumes the core and the host model compiled before it.
*/
`timescale 1ns/1ns
`include "rtc_regs.svh"
module testbench;
  localparam logic [6:0] ID = `RTC_TARGET_ADDR;
  localparam logic [7:0] RSTV [8] = '{8'h80, 8'h00, 8'h00, 8'h01,
                                      8'h01, 8'h01, 8'h00, 8'h03};
  localparam logic [7:0] MSK [8] = '{8'hFF, 8'h7F, 8'h7F, 8'h07,
                                     8'h3F, 8'h1F, 8'hFF, 8'h93};
  localparam logic [7:0] SQC [6] = '{8'h80, 8'h00, 8'h10, 8'h11,
                                     8'h12, 8'h13};
  localparam int SQN [6] = '{0, 0, 0, 16, 32, 128};
  logic        clk, rst, scl, hostOe, sdaOe, sdaOut, pf, xtal;
  logic        sqwOe, sqwPin, xOut, xOe, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [7:0]  b;
  int          badCount, checksDone;
  // Pull-up: the line is low only while someone pulls it.
  wire sda = !(hostOe || sdaOe === 1'b1);

  serial_rtc_calendar_core uut (
    .clk, .rst, .sclPin(scl), .sdaIn(sda), .sdaOut, .sdaOe,
    .crystalInPin(xtal), .crystalOutPin(xOut), .crystalOutOe(xOe),
    .powerFailIn(pf), .squareWavePin(sqwPin), .squareWaveOe(sqwOe),
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  i2c_host_model #(.Q(8)) host (.clk, .sda, .scl, .sdaOe(hostOe));

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Crystal runs far above its real rate so rates show in few cycles.
  initial begin
    xtal = 1'b0;
    forever begin
      repeat (4) @(posedge clk);
      xtal <= ~xtal;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e) begin
      badCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic printVerdict;
    if (badCount == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : printVerdict
  // Bounded wait for ready; running out ends the run as a failure.
  task automatic waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      badCount++;
      printVerdict();
    end
  endtask : waitRdy
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy();
    rv = hrdata;
  endtask : ahb
  task automatic rdchk(input logic [5:0] i, input logic [7:0] e);
    ahb(1'b0, {24'h0, i, 2'b00}, 32'h0);
    chk(rv, {24'h0, e});
  endtask : rdchk
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    ahb(1'b1, {24'h0, i, 2'b00}, {24'h0, d});
  endtask : wr
  task automatic txchk(input logic [7:0] v, input logic e);
    logic a;
    host.tx(v, a);
    chk({31'h0, a}, {31'h0, e});
  endtask : txchk
  // Counts square-wave edges over a whole number of crystal periods.
  task automatic sqwCount(input logic [7:0] c, input int e);
    int n;
    logic p;
    wr(6'h07, c);
    repeat (16) @(posedge clk);
    n = 0;
    p = sqwOe;
    repeat (512) begin
      @(posedge clk);
      if (sqwOe !== p) n++;
      p = sqwOe;
    end
    chk(32'(n), 32'(e));
    if (!c[4]) chk({31'h0, sqwOe}, {31'h0, !c[7]});
    chk({31'h0, sqwPin}, 32'h0);
  endtask : sqwCount

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    pf = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    badCount = 0;
    checksDone = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) rdchk(6'(i), RSTV[i]);
    rdchk(6'h08, 8'h00);
    chk({31'h0, xOut}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(6'(i), 8'hFF);
      rdchk(6'(i), MSK[i]);
    end
    ahb(1'b1, 32'h100, 32'h55);
    ahb(1'b0, 32'h100, 32'h0);
    chk(rv, 32'h0);
    rdchk(6'h00, 8'hFF);
    wr(6'h00, 8'h12);
    wr(6'h3E, 8'h5C);
    // Write across the top of the map into the seconds register.
    host.start();
    txchk({ID, 1'b0}, 1'b1);
    txchk(8'h3F, 1'b1);
    txchk(8'h11, 1'b1);
    txchk(8'h34, 1'b1);
    host.stop();
    rdchk(6'h3F, 8'h11);
    rdchk(6'h00, 8'h34);
    // Read back with a repeated start, wrapping again.
    host.start();
    txchk({ID, 1'b0}, 1'b1);
    txchk(8'h3E, 1'b1);
    host.start();
    txchk({ID, 1'b1}, 1'b1);
    host.rx(1'b1, b);
    chk({24'h0, b}, 32'h5C);
    host.rx(1'b1, b);
    chk({24'h0, b}, 32'h11);
    host.rx(1'b0, b);
    chk({24'h0, b}, 32'h34);
    host.stop();
    host.start();
    txchk({ID ^ 7'h01, 1'b0}, 1'b0);
    host.stop();
    for (int i = 0; i < 6; i++) sqwCount(SQC[i], SQN[i]);
    wr(6'h00, 8'h80);
    sqwCount(8'h11, 0);
    wr(6'h00, 8'h21);
    // Supply fails while the core acknowledges the register address, so
    // the abort has to pull its own acknowledge back.
    host.start();
    txchk({ID, 1'b0}, 1'b1);
    fork
      txchk(8'h09, 1'b0);
      begin
        repeat (260) @(posedge clk);
        pf <= 1'b1;
      end
    join
    txchk(8'h77, 1'b0);
    host.stop();
    sqwCount(8'h11, 16);
    rdchk(6'h09, 8'h00);
    pf <= 1'b0;
    repeat (8) @(posedge clk);
    host.start();
    txchk({ID, 1'b1}, 1'b1);
    host.rx(1'b0, b);
    chk({24'h0, b}, 32'h21);
    host.stop();
    printVerdict();
  end
endmodule : testbench
